/* File: rtl/dac_cfg_pkg.sv */
// Package with register map, field positions, defaults and source select codes.
package dac_cfg_pkg;
    // ************************************************************
    // Register addresses.
    // ************************************************************
    localparam logic [7:0] ADDR_DAC_SOURCE = 8'h14;
    localparam logic [7:0] ADDR_INPUT_SETTINGS = 8'h30;
    localparam logic [7:0] ADDR_SUPPLEMENTAL = 8'h40;
    localparam logic [7:0] ADDR_COARSE_RATIO = 8'h62;
    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int SRC_SEL_HI = 9;
    localparam int SRC_SEL_LO = 8;
    localparam int BIT_COMBINE_PCM = 3;
    localparam int BIT_BURST_MUTE = 2;
    localparam int BIT_KEEP_ZERO = 1;
    localparam int BIT_SLICER_SEL = 0;
    localparam int BIT_XTAL_OUT_EN = 15;
    localparam int BIT_PULLIN = 10;
    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [1:0] RST_SRC_SEL = 2'h2;
    localparam logic RST_COMBINE_PCM = 1'h1;
    localparam logic RST_BURST_MUTE = 1'h1;
    localparam logic RST_SLICER_SEL = 1'h0;
    localparam logic RST_XTAL_OUT_EN = 1'h0;
    localparam logic RST_PULLIN = 1'h0;
    localparam logic [15:0] RST_COARSE = 16'h0300;
    // ************************************************************
    // Source selection codes.
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_SERIAL_PLL_DIG = 2'h0,
        SRC_SERIAL_PLL_WS = 2'h1,
        SRC_DIGITAL_PLL = 2'h2,
        SRC_SERIAL_XTAL = 2'h3
    } src_sel_t;
endpackage : dac_cfg_pkg

/* File: rtl/dac_cfg_if.sv */
// Interface carrying configuration fields from the register bank to the router.
interface dac_cfg_if;
    logic [1:0] src_sel;
    logic combine_pcm;
    logic burst_auto_mute_enable;
    logic slicer_input_select;
    logic xtal_output_enable;
    modport bank (output src_sel, combine_pcm, burst_auto_mute_enable, slicer_input_select,
        xtal_output_enable);
    modport route (input src_sel, combine_pcm, burst_auto_mute_enable, slicer_input_select,
        xtal_output_enable);
endinterface : dac_cfg_if

/* File: rtl/dac_cfg_router.sv */
// Combinational routing of sources, lock indicator, auto-mute and oscillator output.
module dac_cfg_router
    import dac_cfg_pkg::*;
(
    // Configuration.
    dac_cfg_if.route cfg,
    // Status and pins.
    input wire logic i_xtal_power_on,
    input wire logic i_xtal_clk,
    input wire logic i_digital_audio_pin_a,
    input wire logic i_digital_audio_pin_b,
    input wire logic i_lock_raw,
    input wire logic i_pcm_detect,
    input wire logic i_burst_detect,
    // Results.
    output logic o_slicer_in,
    output logic o_lock,
    output logic o_burst_mute,
    output logic o_osc_out,
    output logic o_osc_out_en,
    output logic o_dac_from_digital,
    output logic o_dac_clk_xtal,
    output logic o_pll_ref_ws
);
    always_comb begin
        o_slicer_in = cfg.slicer_input_select ? i_digital_audio_pin_b
                                              : i_digital_audio_pin_a;
        o_lock = cfg.combine_pcm ? (i_lock_raw & i_pcm_detect) : i_lock_raw;
        o_burst_mute = cfg.burst_auto_mute_enable & i_burst_detect;
        o_osc_out_en = cfg.xtal_output_enable & i_xtal_power_on;
        o_osc_out = o_osc_out_en & i_xtal_clk;
        o_dac_from_digital = 1'b0;
        o_dac_clk_xtal = 1'b0;
        o_pll_ref_ws = 1'b0;
        case (src_sel_t'(cfg.src_sel))
            SRC_SERIAL_PLL_WS: begin
                o_pll_ref_ws = 1'b1;
            end
            SRC_DIGITAL_PLL: begin
                o_dac_from_digital = 1'b1;
            end
            SRC_SERIAL_XTAL: begin
                o_dac_clk_xtal = 1'b1;
            end
            default: begin
                o_pll_ref_ws = 1'b0;
            end
        endcase
    end
endmodule : dac_cfg_router

/* File: rtl/audio_dac_source_pll_config.sv */
// Write-only configuration bank for DAC source, digital input, oscillator and PLL ratio.
module audio_dac_source_pll_config
    import dac_cfg_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Register write port.
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_addr,
    input wire logic [15:0] i_wr_data,
    // Device status and pins.
    input wire logic i_xtal_power_on,
    input wire logic i_xtal_clk,
    input wire logic i_digital_audio_pin_a,
    input wire logic i_digital_audio_pin_b,
    input wire logic i_lock_raw,
    input wire logic i_pcm_detect,
    input wire logic i_burst_detect,
    // Routing results.
    output logic o_slicer_in,
    output logic o_lock,
    output logic o_burst_mute,
    output logic o_osc_out,
    output logic o_osc_out_en,
    output logic o_dac_from_digital,
    output logic o_dac_clk_xtal,
    output logic o_pll_ref_ws,
    // Configuration values.
    output logic [1:0] o_src_sel,
    output logic o_pll_pullin_range,
    output logic [15:0] o_pll_coarse_value
);
    // ************************************************************
    // Register state.
    // ************************************************************
    logic [1:0] src_q, src_d;
    logic comb_q, comb_d, burst_q, burst_d, slice_q, slice_d;
    logic xout_q, xout_d, pull_q, pull_d;
    logic [15:0] cr_q, cr_d;
    dac_cfg_if cfg ();

    // ************************************************************
    // Address decode.
    // ************************************************************
    function automatic logic wr_hit(input logic en, input logic [7:0] addr,
        input logic [7:0] target);
        return en && (addr == target);
    endfunction : wr_hit

    always_comb begin
        src_d = src_q;
        comb_d = comb_q;
        burst_d = burst_q;
        slice_d = slice_q;
        xout_d = xout_q;
        pull_d = pull_q;
        cr_d = cr_q;
        if (wr_hit(i_wr_en, i_wr_addr, ADDR_DAC_SOURCE)) begin
            src_d = i_wr_data[SRC_SEL_HI:SRC_SEL_LO];
        end else if (wr_hit(i_wr_en, i_wr_addr, ADDR_INPUT_SETTINGS)) begin
            comb_d = i_wr_data[BIT_COMBINE_PCM];
            burst_d = i_wr_data[BIT_BURST_MUTE];
            slice_d = i_wr_data[BIT_SLICER_SEL];
        end else if (wr_hit(i_wr_en, i_wr_addr, ADDR_SUPPLEMENTAL)) begin
            xout_d = i_wr_data[BIT_XTAL_OUT_EN];
            pull_d = i_wr_data[BIT_PULLIN];
        end else if (wr_hit(i_wr_en, i_wr_addr, ADDR_COARSE_RATIO)) begin
            cr_d = i_wr_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_q <= RST_SRC_SEL;
            comb_q <= RST_COMBINE_PCM;
            burst_q <= RST_BURST_MUTE;
            slice_q <= RST_SLICER_SEL;
            xout_q <= RST_XTAL_OUT_EN;
            pull_q <= RST_PULLIN;
            cr_q <= RST_COARSE;
        end else begin
            src_q <= src_d;
            comb_q <= comb_d;
            burst_q <= burst_d;
            slice_q <= slice_d;
            xout_q <= xout_d;
            pull_q <= pull_d;
            cr_q <= cr_d;
        end
    end

    assign cfg.src_sel = src_q;
    assign cfg.combine_pcm = comb_q;
    assign cfg.burst_auto_mute_enable = burst_q;
    assign cfg.slicer_input_select = slice_q;
    assign cfg.xtal_output_enable = xout_q;
    assign o_src_sel = src_q;
    assign o_pll_pullin_range = pull_q;
    assign o_pll_coarse_value = cr_q;

    // ************************************************************
    // Routing.
    // ************************************************************
    dac_cfg_router u_router (
        .cfg(cfg.route),
        .i_xtal_power_on(i_xtal_power_on),
        .i_xtal_clk(i_xtal_clk),
        .i_digital_audio_pin_a(i_digital_audio_pin_a),
        .i_digital_audio_pin_b(i_digital_audio_pin_b),
        .i_lock_raw(i_lock_raw),
        .i_pcm_detect(i_pcm_detect),
        .i_burst_detect(i_burst_detect),
        .o_slicer_in(o_slicer_in),
        .o_lock(o_lock),
        .o_burst_mute(o_burst_mute),
        .o_osc_out(o_osc_out),
        .o_osc_out_en(o_osc_out_en),
        .o_dac_from_digital(o_dac_from_digital),
        .o_dac_clk_xtal(o_dac_clk_xtal),
        .o_pll_ref_ws(o_pll_ref_ws)
    );

    // ************************************************************
    // Checks.
    // ************************************************************
    a_src_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        wr_hit(i_wr_en, i_wr_addr, ADDR_DAC_SOURCE) |=>
        o_src_sel == $past(i_wr_data[SRC_SEL_HI:SRC_SEL_LO]))
        else $error("Source selector not loaded.");
    a_coarse_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr_en && i_wr_addr == ADDR_COARSE_RATIO) |=> o_pll_coarse_value == $past(i_wr_data))
        else $error("Coarse ratio not loaded.");
    a_coarse_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !(i_wr_en && i_wr_addr == ADDR_COARSE_RATIO) |=> $stable(o_pll_coarse_value))
        else $error("Coarse ratio changed without write.");
    a_pull_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        wr_hit(i_wr_en, i_wr_addr, ADDR_SUPPLEMENTAL) |=>
        o_pll_pullin_range == $past(i_wr_data[BIT_PULLIN]))
        else $error("Pull-in bit not loaded.");
    a_osc_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_osc_out_en == (xout_q && i_xtal_power_on))
        else $error("Oscillator output gating wrong.");
    a_slicer_pick: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_slicer_in == (slice_q ? i_digital_audio_pin_b : i_digital_audio_pin_a))
        else $error("Slicer input wrong.");
    a_lock_combine: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (comb_q && !i_pcm_detect) |-> !o_lock)
        else $error("Lock ignores PCM detection.");
    a_burst_mute: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_burst_mute == (burst_q && i_burst_detect))
        else $error("Burst mute wrong.");
    a_src_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_dac_from_digital == (o_src_sel == SRC_DIGITAL_PLL)
        && o_dac_clk_xtal == (o_src_sel == SRC_SERIAL_XTAL)
        && o_pll_ref_ws == (o_src_sel == SRC_SERIAL_PLL_WS))
        else $error("Source routing wrong.");
    a_route_onehot: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        $onehot0({o_dac_from_digital, o_dac_clk_xtal, o_pll_ref_ws}))
        else $error("More than one routing flag raised.");
    a_input_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        wr_hit(i_wr_en, i_wr_addr, ADDR_INPUT_SETTINGS) |=>
        {comb_q, burst_q, slice_q} == {$past(i_wr_data[BIT_COMBINE_PCM]),
        $past(i_wr_data[BIT_BURST_MUTE]), $past(i_wr_data[BIT_SLICER_SEL])})
        else $error("Input settings not loaded.");
    a_xout_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        wr_hit(i_wr_en, i_wr_addr, ADDR_SUPPLEMENTAL) |=>
        xout_q == $past(i_wr_data[BIT_XTAL_OUT_EN]))
        else $error("Oscillator enable not loaded.");
    a_src_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !wr_hit(i_wr_en, i_wr_addr, ADDR_DAC_SOURCE) |=> $stable(o_src_sel))
        else $error("Source selector changed without write.");
    a_input_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !wr_hit(i_wr_en, i_wr_addr, ADDR_INPUT_SETTINGS) |=>
        $stable({comb_q, burst_q, slice_q}))
        else $error("Input settings changed without write.");
    a_supp_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !wr_hit(i_wr_en, i_wr_addr, ADDR_SUPPLEMENTAL) |=>
        $stable({xout_q, pull_q}))
        else $error("Supplemental settings changed without write.");
    a_unmapped_ignore: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr_en && !wr_hit(1'h1, i_wr_addr, ADDR_DAC_SOURCE)
        && !wr_hit(1'h1, i_wr_addr, ADDR_INPUT_SETTINGS)
        && !wr_hit(1'h1, i_wr_addr, ADDR_SUPPLEMENTAL)
        && !wr_hit(1'h1, i_wr_addr, ADDR_COARSE_RATIO)) |=> $stable(o_src_sel)
        && $stable(o_pll_coarse_value) && $stable(o_pll_pullin_range))
        else $error("Unmapped write altered a register.");
    a_reset_values: assert property (@(posedge i_mclk)
        $rose(i_rstn) |-> (o_src_sel == RST_SRC_SEL
        && o_pll_coarse_value == RST_COARSE && o_pll_pullin_range == RST_PULLIN
        && {comb_q, burst_q, slice_q, xout_q} == {RST_COMBINE_PCM, RST_BURST_MUTE,
        RST_SLICER_SEL, RST_XTAL_OUT_EN}))
        else $error("Register off its default after reset.");
    a_lock_plain: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !comb_q |-> o_lock == i_lock_raw)
        else $error("Lock indicator altered while not combined.");
    a_lock_merged: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (comb_q && i_pcm_detect) |-> o_lock == i_lock_raw)
        else $error("Lock indicator lost with PCM detected.");
    a_lock_raw_low: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !i_lock_raw |-> !o_lock)
        else $error("Lock indicator raised without lock.");
    a_osc_out: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_osc_out |-> (xout_q && i_xtal_power_on && i_xtal_clk))
        else $error("Oscillator pin driven while disabled.");
    a_osc_follow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_osc_out_en |-> o_osc_out == i_xtal_clk)
        else $error("Oscillator pin does not follow crystal.");
    c_coarse_write: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        i_wr_en && i_wr_addr == ADDR_COARSE_RATIO);
    c_osc_on: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_osc_out_en);
    c_src_xtal: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_dac_clk_xtal);
    c_burst_mute: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_burst_mute);
    c_ref_ws: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_pll_ref_ws);
endmodule : audio_dac_source_pll_config

/* File: verif/host_writer.sv */
// Host model that issues register writes on the falling clock edge.
module host_writer
    import dac_cfg_pkg::*;
(
    // Clock.
    input wire logic i_mclk,
    // Write port.
    output logic o_wr_en,
    output logic [7:0] o_wr_addr,
    output logic [15:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_wr_en = 1'h0;
        o_wr_addr = 8'h00;
        o_wr_data = 16'h0000;
    end
    // Legal writes clear bits that must stay zero; data is inverted once released.
    task wr(input logic [7:0] a, input logic [15:0] d, input logic legal);
        logic [15:0] v;
        v = d;
        if (legal && a == ADDR_INPUT_SETTINGS) v[BIT_KEEP_ZERO] = 1'h0;
        if (legal && a == ADDR_SUPPLEMENTAL) begin
            v = v & ((16'h0001 << BIT_XTAL_OUT_EN) | (16'h0001 << BIT_PULLIN));
        end
        @(negedge i_mclk);
        o_wr_en <= 1'h1;
        o_wr_addr <= a;
        o_wr_data <= v;
        @(negedge i_mclk);
        o_wr_en <= 1'h0;
        o_wr_data <= ~v;
    endtask : wr
endmodule : host_writer

/* File: verif/audio_dac_source_pll_config_tb.sv */
// Testbench for the configuration bank with a host model driving writes.
module audio_dac_source_pll_config_tb;
    import dac_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'h0, i_rstn = 1'h0, wr_en;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic pwr = 1'h1, xclk = 1'h1, pin_a = 1'h0, pin_b = 1'h1;
    logic lock_raw = 1'h1, pcm = 1'h0, burst = 1'h1;
    logic slicer, lock, mute, osc, osc_en, dig, xtal, ws, pullin;
    logic [1:0] src;
    logic [15:0] coarse;
    int failures = 0, samples_checked = 0;
    initial forever #2.5 i_mclk = ~i_mclk;
    host_writer u_host (.i_mclk(i_mclk), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data));
    audio_dac_source_pll_config u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_en(wr_en),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_xtal_power_on(pwr), .i_xtal_clk(xclk),
        .i_digital_audio_pin_a(pin_a), .i_digital_audio_pin_b(pin_b), .i_lock_raw(lock_raw),
        .i_pcm_detect(pcm), .i_burst_detect(burst), .o_slicer_in(slicer), .o_lock(lock),
        .o_burst_mute(mute), .o_osc_out(osc), .o_osc_out_en(osc_en),
        .o_dac_from_digital(dig), .o_dac_clk_xtal(xtal), .o_pll_ref_ws(ws), .o_src_sel(src),
        .o_pll_pullin_range(pullin), .o_pll_coarse_value(coarse));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task check_defaults();
        chk(src, 16'h0002);
        chk(dig, 16'h0001);
        chk(pullin, 16'h0000);
        chk(coarse, 16'h0300);
        chk(lock, 16'h0000);
        chk(mute, 16'h0001);
        chk(slicer, 16'h0000);
        chk(osc_en, 16'h0000);
        chk({xtal, ws, osc}, 16'h0000);
    endtask : check_defaults
    task source_codes();
        for (int c = 0; c < 4; c++) begin
            u_host.wr(ADDR_DAC_SOURCE, 16'(c) << 8, 1'h1);
            chk(src, 16'(c));
            chk({dig, xtal, ws}, {c == 2, c == 3, c == 1});
        end
    endtask : source_codes
    task input_settings();
        u_host.wr(ADDR_INPUT_SETTINGS, 16'h0001, 1'h1);
        chk(lock, 16'h0001);
        chk(mute, 16'h0000);
        chk(slicer, 16'h0001);
        pin_b = 1'h0;
        pcm = 1'h1;
        @(negedge i_mclk);
        chk({slicer, lock}, 16'h0001);
        pin_b = 1'h1;
        pcm = 1'h0;
        burst = 1'h0;
        u_host.wr(ADDR_INPUT_SETTINGS, 16'hFFFE, 1'h0);
        chk({lock, mute, slicer}, 16'h0000);
        burst = 1'h1;
        pcm = 1'h1;
        pin_a = 1'h1;
        @(negedge i_mclk);
        chk({lock, mute, slicer}, 16'h0007);
        lock_raw = 1'h0;
        pin_a = 1'h0;
        @(negedge i_mclk);
        chk({lock, mute, slicer}, 16'h0002);
        lock_raw = 1'h1;
        pcm = 1'h0;
    endtask : input_settings
    task supplemental();
        u_host.wr(ADDR_SUPPLEMENTAL, 16'hFFFF, 1'h1);
        chk(pullin, 16'h0001);
        chk({osc_en, osc}, 16'h0003);
        xclk = 1'h0;
        @(negedge i_mclk);
        chk({osc_en, osc}, 16'h0002);
        xclk = 1'h1;
        pwr = 1'h0;
        @(negedge i_mclk);
        chk({osc_en, osc}, 16'h0000);
        pwr = 1'h1;
        u_host.wr(ADDR_SUPPLEMENTAL, 16'h0400, 1'h1);
        chk({osc_en, pullin}, 16'h0001);
        u_host.wr(ADDR_SUPPLEMENTAL, 16'h7BFF, 1'h0);
        chk({osc_en, osc, pullin}, 16'h0000);
    endtask : supplemental
    task coarse_ratios();
        static logic [15:0] tbl [6] = '{16'd320, 16'd441, 16'd882, 16'd1280, 16'd1764,
            16'd1920};
        foreach (tbl[i]) begin
            u_host.wr(ADDR_COARSE_RATIO, tbl[i], 1'h1);
            chk(coarse, tbl[i]);
        end
        u_host.wr(8'h63, 16'h1234, 1'h1);
        chk(coarse, 16'd1920);
        u_host.wr(ADDR_COARSE_RATIO, RST_COARSE, 1'h1);
        chk(coarse, 16'h0300);
    endtask : coarse_ratios
    task give_verdict();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (4) @(negedge i_mclk);
        i_rstn = 1'h1;
        check_defaults();
        source_codes();
        input_settings();
        supplemental();
        coarse_ratios();
        u_host.wr(ADDR_INPUT_SETTINGS, 16'h0001, 1'h1);
        u_host.wr(ADDR_SUPPLEMENTAL, 16'hFFFF, 1'h1);
        u_host.wr(ADDR_COARSE_RATIO, 16'h01B9, 1'h1);
        chk({src, pullin, slicer}, 16'h000F);
        @(negedge i_mclk);
        i_rstn = 1'h0;
        @(negedge i_mclk);
        i_rstn = 1'h1;
        check_defaults();
        give_verdict();
    end
endmodule : audio_dac_source_pll_config_tb
